// >>> src/aop_top.sv
// Purpose: angle refresh, serial snapshot, PWM generation and power-up reload
// Assumes: raw angle, zcd, gauss and fault inputs come from same-clock logic
// Notes:   serial pins are asynchronous and pass two flip-flops first
`include "aop_regs.svh"
module aop_top
    import aop_pkg::*;
#(
    parameter int PWM_BASE_CYC = `AOP_PWM_BASE_CYC,
    parameter int INIT_CYC     = `AOP_INIT_CYC,
    parameter int LAT_STAGES   = `AOP_LATENCY_STAGES
) (
    // Clock, reset, enable
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        clkEn,
    // APB slave
    input  wire logic [11:0] paddr,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Data path and nonvolatile shadow source
    input  wire logic [14:0] rawAngle,
    input  wire logic [14:0] zcdIn,
    input  wire logic [15:0] gaussIn,
    input  wire logic [11:0] faultIn,
    input  wire logic [14:0] nvmZeroOffset,
    input  wire logic [31:0] nvmCtrl,
    // Serial pins
    input  wire logic        csN,
    input  wire logic        sclk,
    output logic             miso,
    output logic             misoOe,
    // PWM pin
    output logic             pwmOut,
    output logic             pwmOe,
    // Incremental and commutation feed
    output logic [14:0]      incAngle,
    output logic             incUpdate,
    output logic             initDone
);
    // Highest-priority active fault; bit 0 is the watchdog fault
    function automatic logic [3:0] faultIndex(input logic [11:0] f);
        logic [3:0] idx;
        idx = 4'hF;
        for (int i = 11; i >= 0; i--) begin
            if (f[i]) begin
                idx = 4'(i);
            end
        end
        return idx;
    endfunction

    aop_init_st_t st_q;
    logic [31:0]  ctrl_q;
    aop_angle_t   zero_q;
    logic [7:0]   wptr_q;
    logic [14:0]  zcd_q;
    logic [15:0]  gauss_q;
    logic [18:0]  initCnt_q;
    logic [4:0]   refCnt_q;
    logic [9:0]   zcdCnt_q;
    logic [11:0]  gaussCnt_q;
    aop_angle_t   pipe_q [LAT_STAGES];
    aop_angle_t   angle_q;
    logic         refTick;
    logic         running;

    assign running = (st_q == AOP_ST_RUN);
    assign refTick = (refCnt_q == 5'(`AOP_REFRESH_CYC - 1));

    // Power-up sequencer: load shadows, wait out the init time, run
    always_ff @(posedge clk) begin
        if (rst) begin
            st_q      <= AOP_ST_LOAD;
            initCnt_q <= 19'h00000;
        end else if (clkEn) begin
            case (st_q)
                AOP_ST_LOAD: begin
                    st_q <= AOP_ST_WAIT;
                end
                AOP_ST_WAIT: begin
                    initCnt_q <= initCnt_q + 19'h00001;
                    if (initCnt_q == 19'(INIT_CYC - 1)) begin
                        st_q <= AOP_ST_RUN;
                    end
                end
                AOP_ST_RUN: begin
                    st_q <= AOP_ST_RUN;
                end
                default: begin
                    st_q <= AOP_ST_LOAD;
                end
            endcase
        end
    end

    // APB handshake: one wait state; a write lands on the completing edge only
    logic        apbWr;
    logic        apbHit;
    always_comb begin
        apbWr  = psel && penable && pwrite && pready;
        apbHit = (paddr == `AOP_CTRL_OFS) || (paddr == `AOP_ZERO_OFS) ||
                 (paddr == `AOP_WPTR_OFS) || (paddr == `AOP_STAT_OFS) ||
                 (paddr == `AOP_ZCD_OFS) || (paddr == `AOP_GAUSS_OFS);
    end

    // Configuration registers; shadows reload from nonvolatile copy at power-up
    always_ff @(posedge clk) begin
        if (rst) begin
            ctrl_q <= `AOP_CTRL_RST;
            zero_q <= 15'h0000;
            wptr_q <= `AOP_WPTR_RST;
        end else if (clkEn) begin
            if (st_q == AOP_ST_LOAD) begin
                ctrl_q <= nvmCtrl;
                zero_q <= nvmZeroOffset;
                wptr_q <= `AOP_WPTR_RST;
            end else if (apbWr) begin
                case (paddr)
                    `AOP_CTRL_OFS: ctrl_q <= pwdata;
                    `AOP_ZERO_OFS: zero_q <= pwdata[14:0];
                    `AOP_WPTR_OFS: wptr_q <= pwdata[7:0];
                    default:       ctrl_q <= ctrl_q;
                endcase
            end
        end
    end

    // Read path; unmapped addresses answer zero with an error
    always_ff @(posedge clk) begin
        if (rst) begin
            prdata  <= 32'h0000_0000;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else if (clkEn) begin
            pready  <= psel && penable && !pready;
            pslverr <= psel && penable && !pready && !apbHit;
            prdata  <= 32'h0000_0000;
            if (psel && penable && !pready && !pwrite) begin
                case (paddr)
                    `AOP_CTRL_OFS:  prdata <= ctrl_q;
                    `AOP_ZERO_OFS:  prdata <= {17'h00000, zero_q};
                    `AOP_WPTR_OFS:  prdata <= {24'h000000, wptr_q};
                    `AOP_STAT_OFS:  prdata <= {12'h000, faultIndex(faultIn),
                                               initDone, angle_q};
                    `AOP_ZCD_OFS:   prdata <= {17'h00000, zcd_q};
                    `AOP_GAUSS_OFS: prdata <= {16'h0000, gauss_q};
                    default:        prdata <= 32'h0000_0000;
                endcase
            end
        end
    end

    // Refresh timers for angle, zero-crossing and field-strength values
    always_ff @(posedge clk) begin
        if (rst) begin
            refCnt_q   <= 5'h00;
            zcdCnt_q   <= 10'h000;
            gaussCnt_q <= 12'h000;
            zcd_q      <= 15'h0000;
            gauss_q    <= 16'h0000;
        end else if (clkEn && running) begin
            refCnt_q <= refTick ? 5'h00 : refCnt_q + 5'h01;
            if (zcdCnt_q == 10'(`AOP_ZCD_CYC - 1)) begin
                zcdCnt_q <= 10'h000;
                zcd_q    <= zcdIn;
            end else begin
                zcdCnt_q <= zcdCnt_q + 10'h001;
            end
            if (gaussCnt_q == 12'(`AOP_GAUSS_CYC - 1)) begin
                gaussCnt_q <= 12'h000;
                gauss_q    <= gaussIn;
            end else begin
                gaussCnt_q <= gaussCnt_q + 12'h001;
            end
        end
    end

    generate
        for (genvar g = 0; g < LAT_STAGES; g++) begin : g_lat
            always_ff @(posedge clk) begin
                if (rst) begin
                    pipe_q[g] <= 15'h0000;
                end else if (clkEn && running && refTick) begin
                    pipe_q[g] <= (g == 0) ? rawAngle : pipe_q[(g == 0) ? 0 : g - 1];
                end
            end
        end
    endgenerate

    // Angle register and incremental feed; zero reference applied here
    always_ff @(posedge clk) begin
        if (rst) begin
            angle_q   <= 15'h0000;
            incAngle  <= 15'h0000;
            incUpdate <= 1'b0;
            initDone  <= 1'b0;
        end else if (clkEn) begin
            initDone  <= running;
            incUpdate <= 1'b0;
            if (running && refTick) begin
                angle_q <= pipe_q[LAT_STAGES - 1] - zero_q;
                if ((pipe_q[LAT_STAGES - 1] - zero_q) != incAngle) begin
                    incAngle  <= pipe_q[LAT_STAGES - 1] - zero_q;
                    incUpdate <= 1'b1;
                end
            end
        end
    end

    // Serial pin synchronisers
    logic [1:0]  csSync_q;
    logic [1:0]  sclkSync_q;
    logic        csOld_q;
    logic        sclkOld_q;
    logic [14:0] shift_q;
    logic [4:0]  bitCnt_q;
    logic [14:0] serWord;
    always_ff @(posedge clk) begin
        if (rst) begin
            csSync_q   <= 2'b11;
            sclkSync_q <= 2'b11;
            csOld_q    <= 1'b1;
            sclkOld_q  <= 1'b1;
        end else if (clkEn) begin
            csSync_q   <= {csSync_q[0], csN};
            sclkSync_q <= {sclkSync_q[0], sclk};
            csOld_q    <= csSync_q[1];
            sclkOld_q  <= sclkSync_q[1];
        end
    end

    always_comb begin
        if (ctrl_q[`AOP_CTRL_SER15_BIT]) begin
            serWord = angle_q;
        end else begin
            serWord = {faultIn != 12'h000, !initDone, ^angle_q[14:3], angle_q[14:3]};
        end
    end

    // Snapshot on select fall, shift on the first 15 falling serial clocks of a frame
    always_ff @(posedge clk) begin
        if (rst) begin
            shift_q  <= 15'h0000;
            bitCnt_q <= 5'h00;
            miso     <= 1'b0;
            misoOe   <= 1'b0;
        end else if (clkEn) begin
            misoOe <= !csSync_q[1];
            if (csOld_q && !csSync_q[1]) begin
                shift_q  <= serWord;
                bitCnt_q <= 5'h00;
                miso     <= 1'b0;
            end else if (!csSync_q[1] && sclkOld_q && !sclkSync_q[1] &&
                         bitCnt_q < 5'(`AOP_SER_BITS - 1)) begin
                miso     <= shift_q[14];
                shift_q  <= {shift_q[13:0], 1'b0};
                bitCnt_q <= bitCnt_q + 5'h01;
            end
        end
    end

    // PWM period from band and fine fields
    logic [2:0]  band;
    logic [3:0]  fine;
    logic [19:0] basePer;
    logic [19:0] nextPer;
    logic [3:0]  errIdx;
    logic        errShow;
    logic [39:0] hiWide;
    logic [19:0] nextHi;
    logic [19:0] per_q;
    logic [19:0] hi_q;
    logic [19:0] cnt_q;
    logic        errLat_q;

    always_comb begin
        band   = ctrl_q[`AOP_CTRL_BAND_LSB +: 3];
        fine   = ctrl_q[`AOP_CTRL_FINE_LSB +: 4];
        errIdx = faultIndex(faultIn);
        errShow = ctrl_q[`AOP_CTRL_PEO_BIT] && (errIdx != 4'hF);
        basePer = 20'(PWM_BASE_CYC - `AOP_PWM_BAND_CYC) +
                  (20'(`AOP_PWM_BAND_CYC) << band) +
                  20'((20'(`AOP_PWM_FINE2_CYC * fine) << band) >> 1);
        nextPer = basePer;
        hiWide  = 40'h00_0000_0000;
        if (errShow && ctrl_q[`AOP_CTRL_PES_BIT]) begin
            nextPer = basePer << 1;
            hiWide  = (40'(nextPer) * (40'd40 + 40'd45 * 40'(errIdx))) / 40'd800;
        end else begin
            hiWide  = (40'(nextPer) * (40'd20480 + 40'd90 * 40'(angle_q[14:3])))
                      / 40'd409600;
        end
        nextHi = hiWide[19:0];
    end

    // Period counter; new period and duty take effect only at a rising edge
    always_ff @(posedge clk) begin
        if (rst) begin
            // Start at the wrap point so the first period loads a real duty
            cnt_q    <= 20'(PWM_BASE_CYC - 1);
            per_q    <= 20'(PWM_BASE_CYC);
            hi_q     <= 20'h00000;
            errLat_q <= 1'b0;
        end else if (clkEn && running) begin
            if (cnt_q >= per_q - 20'h00001) begin
                cnt_q    <= 20'h00000;
                per_q    <= nextPer;
                hi_q     <= nextHi;
                errLat_q <= errShow;
            end else begin
                cnt_q <= cnt_q + 20'h00001;
            end
        end
    end

    // Pin drive; duty never reaches 0% or 100% since hi lies inside the period
    always_ff @(posedge clk) begin
        if (rst) begin
            pwmOut <= 1'b0;
            pwmOe  <= 1'b0;
        end else if (clkEn) begin
            pwmOut <= running && (cnt_q < hi_q);
            pwmOe  <= running && !(errLat_q && !ctrl_q[`AOP_CTRL_PES_BIT]);
        end
    end

endmodule // aop_top

// >>> src/aop_regs.svh
// Purpose: register map, field positions, reset values and timing counts
// Assumes: 25 MHz core clock, APB byte addressing, one register per word
// Notes:   counts derive from times in their own units
`ifndef AOP_REGS_SVH
`define AOP_REGS_SVH
`define AOP_CLK_MHZ          25
// Register byte offsets
`define AOP_CTRL_OFS         12'h000
`define AOP_ZERO_OFS         12'h004
`define AOP_WPTR_OFS         12'h008
`define AOP_STAT_OFS         12'h00C
`define AOP_ZCD_OFS          12'h010
`define AOP_GAUSS_OFS        12'h014
// Control fields
`define AOP_CTRL_PEO_BIT     0
`define AOP_CTRL_PES_BIT     1
`define AOP_CTRL_SER15_BIT   2
`define AOP_CTRL_BAND_LSB    4
`define AOP_CTRL_FINE_LSB    7
`define AOP_CTRL_RST         32'h0000_0000
`define AOP_WPTR_RST         8'h00
// Times and derived cycle counts
`define AOP_REFRESH_NS       1000
`define AOP_REFRESH_CYC      (`AOP_REFRESH_NS * `AOP_CLK_MHZ / 1000)
`define AOP_LATENCY_US       10
`define AOP_LATENCY_STAGES   (`AOP_LATENCY_US * 1000 / `AOP_REFRESH_NS)
`define AOP_SNAP_MAX_NS      125
`define AOP_SNAP_MAX_CYC     (`AOP_SNAP_MAX_NS * `AOP_CLK_MHZ / 1000)
`define AOP_ZCD_US           32
`define AOP_ZCD_CYC          (`AOP_ZCD_US * `AOP_CLK_MHZ)
`define AOP_GAUSS_US         128
`define AOP_GAUSS_CYC        (`AOP_GAUSS_US * `AOP_CLK_MHZ)
`define AOP_INIT_US          100
`define AOP_INIT_CYC         (`AOP_INIT_US * `AOP_CLK_MHZ)
// PWM period: base 320 us, band step 40 us, fine step 2.5 us, both steps doubling per band
`define AOP_PWM_BASE_US      320
`define AOP_PWM_BASE_CYC     (`AOP_PWM_BASE_US * `AOP_CLK_MHZ)
`define AOP_PWM_BAND_US      40
`define AOP_PWM_BAND_CYC     (`AOP_PWM_BAND_US * `AOP_CLK_MHZ)
`define AOP_PWM_FINE_NS      2500
`define AOP_PWM_FINE2_CYC    (2 * `AOP_PWM_FINE_NS * `AOP_CLK_MHZ / 1000)
`define AOP_SER_BITS         16
`endif

// >>> src/aop_pkg.sv
// Purpose: shared types of the angle output block
// Assumes: constants live in aop_regs.svh
// Notes:   init sequencer states are Gray coded along the path
package aop_pkg;
    typedef enum logic [1:0] {
        AOP_ST_LOAD = 2'b00,
        AOP_ST_WAIT = 2'b01,
        AOP_ST_RUN  = 2'b11
    } aop_init_st_t;
    typedef logic [14:0] aop_angle_t;
endpackage

// >>> testbench/aop_top_sva.sv
// Purpose: port assertions for the angle output block
// Assumes: one core clock, synchronous active-high reset
// Notes:   serial pins pass two sync flops, so the windows are short
module aop_top_sva #(
    parameter int INIT_CYC = 4
) (
    // Clock and reset
    input wire logic        clk,
    input wire logic        rst,
    // APB
    input wire logic        psel,
    input wire logic        penable,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    // Serial, PWM and angle
    input wire logic        csN,
    input wire logic        miso,
    input wire logic        misoOe,
    input wire logic        pwmOut,
    input wire logic [14:0] incAngle,
    input wire logic        incUpdate,
    input wire logic        initDone
);
    logic [15:0] upCnt_q;
    // Cycles since reset release; saturates so a long run never wraps
    always_ff @(posedge clk) begin
        if (rst) begin
            upCnt_q <= 16'h0000;
        end else if (upCnt_q != 16'hFFFF) begin
            upCnt_q <= upCnt_q + 16'h0001;
        end
    end
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);
    rdy_wait_a: assert property (psel && penable && !$past(penable) |-> !pready ##1 pready)
        else $error("apb answer not after one wait state");
    rdy_pulse_a: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    err_pair_a: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    rdat_idle_a: assert property (!pready |-> prdata == 32'h0000_0000)
        else $error("prdata not zero outside answer");
    init_early_a: assert property (upCnt_q < INIT_CYC |-> !initDone)
        else $error("init done too early");
    snap_time_a: assert property ($fell(csN) |-> ##[1:3] misoOe)
        else $error("serial snapshot late");
    first_bit_a: assert property ($rose(misoOe) |-> !miso)
        else $error("first serial bit not empty");
    inc_change_a: assert property (incUpdate |-> incAngle != $past(incAngle))
        else $error("update pulse without angle change");
    inc_hold_a: assert property (!incUpdate |-> $stable(incAngle))
        else $error("angle moved without update pulse");
    pwm_clamp_a: assert property ($rose(pwmOut) |=> pwmOut [*8])
        else $error("pwm high time below clamp");
    // Main scenarios reached
    cover property (incUpdate);
    cover property ($rose(misoOe));
    cover property (pready && pslverr);
endmodule // aop_top_sva

bind aop_top aop_top_sva #(.INIT_CYC(INIT_CYC)) sva_u (
    .clk(clk), .rst(rst), .psel(psel), .penable(penable), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .csN(csN), .miso(miso), .misoOe(misoOe),
    .pwmOut(pwmOut), .incAngle(incAngle), .incUpdate(incUpdate), .initDone(initDone)
);

// >>> testbench/aop_host_model.sv
// Purpose: host reading the serial angle and timing the PWM pin
// Assumes: sclk idles high and stands still between frames
// Notes:   released pins read as pulled up, never as the last value
module aop_host_model (
    // Core clock for pacing
    input  wire logic clk,
    // Serial pins
    output logic      csN,
    output logic      sclk,
    input  wire logic miso,
    input  wire logic misoOe,
    // PWM pin
    input  wire logic pwmOut,
    input  wire logic pwmOe
);
    timeunit 1ns;
    timeprecision 1ns;
    logic misoLine;
    logic pwmLine;
    // Pull-ups on both lines
    assign misoLine = misoOe ? miso : 1'b1;
    assign pwmLine  = pwmOe ? pwmOut : 1'b1;
    // Idle levels
    initial begin
        csN  = 1'b1;
        sclk = 1'b1;
    end
    // One frame; half is the sclk half period in core cycles, 5 or more
    task automatic readWord(input int half, output logic [15:0] word);
        @(posedge clk);
        csN <= 1'b0;
        repeat (half) @(posedge clk);
        for (int i = 15; i >= 0; i--) begin
            word[i] = misoLine;
            sclk <= 1'b0;
            repeat (half) @(posedge clk);
            sclk <= 1'b1;
            repeat (half) @(posedge clk);
        end
        csN <= 1'b1;
        repeat (5) @(posedge clk);
    endtask
    // High and whole period of one PWM cycle, in core cycles
    task automatic measure(output int per, output int hi);
        int n;
        n  = 0;
        hi = 0;
        while (pwmLine !== 1'b0 && n < 9000) begin
            @(posedge clk);
            n++;
        end
        while (pwmLine !== 1'b1 && n < 9000) begin
            @(posedge clk);
            n++;
        end
        while (pwmLine === 1'b1 && n < 9000) begin
            @(posedge clk);
            hi++;
            n++;
        end
        per = hi;
        while (pwmLine === 1'b0 && n < 9000) begin
            @(posedge clk);
            per++;
            n++;
        end
    endtask
endmodule // aop_host_model

// >>> testbench/tb_top.sv
// Purpose: self-checking bench for the angle output block
// Assumes: host model drives serial pins and times the PWM pin
// Notes:   short PWM base and init counts keep the run brief
`include "aop_regs.svh"
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clk, rst, clkEn, psel, penable, pwrite, pready, pslverr;
    logic        csN, sclk, miso, misoOe, pwmOut, pwmOe, incUpdate, initDone;
    logic [11:0] paddr, faultIn;
    logic [31:0] pwdata, prdata, nvmCtrl, rdBack;
    logic [14:0] rawAngle, zcdIn, nvmZeroOffset, incAngle;
    logic [15:0] gaussIn, w;
    int          err_count, checked, per, hi, basePer;

    aop_top #(.PWM_BASE_CYC(800), .INIT_CYC(4), .LAT_STAGES(10)) dut_u (
        .clk(clk), .rst(rst), .clkEn(clkEn), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .rawAngle(rawAngle), .zcdIn(zcdIn),
        .gaussIn(gaussIn), .faultIn(faultIn), .nvmZeroOffset(nvmZeroOffset),
        .nvmCtrl(nvmCtrl), .csN(csN), .sclk(sclk), .miso(miso), .misoOe(misoOe),
        .pwmOut(pwmOut), .pwmOe(pwmOe), .incAngle(incAngle), .incUpdate(incUpdate),
        .initDone(initDone));
    aop_host_model host_u (.clk(clk), .csN(csN), .sclk(sclk), .miso(miso),
        .misoOe(misoOe), .pwmOut(pwmOut), .pwmOe(pwmOe));

    // 25 MHz core clock
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    // Compare one value
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            err_count++;
            $display("[ERR] %s exp %h got %h", what, exp, got);
        end
    endtask
    // One APB transfer, held until pready is seen at an edge
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] r);
        int n;
        n = 0;
        @(posedge clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (pready !== 1'b1) begin
            err_count++;
            $display("[ERR] pready exp 1 got %b", pready);
        end
        r = {prdata[31:1], prdata[0] | pslverr};
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask
    // Read and compare; bit 0 also carries pslverr
    task automatic rdChk(input string what, input logic [11:0] a, input logic [31:0] exp);
        logic [31:0] r;
        apb(1'b0, a, 32'h0, r);
        chk(what, exp, r);
    endtask
    // Reset for six cycles, then wait for the init sequence
    task automatic doReset();
        int n;
        n = 0;
        rst <= 1'b1;
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        while (initDone !== 1'b1 && n < 100) begin
            @(posedge clk);
            n++;
        end
        chk("initDone", 32'h1, {31'h0, initDone});
    endtask
    // Verdict and end of run
    task automatic results();
        $display("compares %0d mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    // Shadow reload and pointer clear across a second power-up
    task automatic test_reset();
        logic [31:0] r;
        doReset();
        rdChk("ctrl", `AOP_CTRL_OFS, nvmCtrl);
        apb(1'b1, `AOP_ZERO_OFS, 32'h0, r);
        apb(1'b1, `AOP_WPTR_OFS, 32'h5A, r);
        rdChk("wptrW", `AOP_WPTR_OFS, 32'h5A);
        doReset();
        rdChk("zero", `AOP_ZERO_OFS, 32'h10);
        rdChk("wptr", `AOP_WPTR_OFS, 32'h0);
        rdChk("unmapped", 12'h0FC, 32'h1);
        $display("reset test done");
    endtask
    // Angle delay, quiet stream, then serial words in both modes
    task automatic test_angle();
        int n;
        n = 0;
        rawAngle <= 15'h1234;
        do begin
            @(posedge clk);
            n++;
        end while (!(incUpdate === 1'b1 && incAngle === 15'h1224) && n < 400);
        chk("angle", 32'h1224, {17'h0, incAngle});
        chk("latency", 32'h1, {31'h0, n >= 200 && n <= 280});
        n = 0;
        repeat (200) begin
            @(posedge clk);
            n += int'(incUpdate === 1'b1);
        end
        chk("quiet", 32'h0, n);
        rdChk("status", `AOP_STAT_OFS, 32'h000F_9224);
        host_u.readWord(5, w);
        chk("word15", 32'h1224, {16'h0, w});
        apb(1'b1, `AOP_CTRL_OFS, 32'h0, rdBack);
        host_u.readWord(9, w);
        chk("word12", 32'h1244, {16'h0, w});
        $display("angle test done");
    endtask
    // Duty at both clamps, then error signalling in every mode
    task automatic test_pwm();
        for (int i = 0; i < 2; i++) begin
            rawAngle <= 15'h0010 - 15'(i);
            repeat (300) @(posedge clk);
            host_u.measure(per, hi);
            host_u.measure(per, hi);
            chk("period", 32'h320, per);
            chk("high", per * (20480 + 90 * 4095 * i) / 409600, hi);
        end
        basePer = per;
        faultIn <= 12'h088;
        rdChk("fault", `AOP_STAT_OFS, 32'h0003_FFFF);
        host_u.measure(per, hi);
        chk("errOff", basePer, per);
        apb(1'b1, `AOP_CTRL_OFS, 32'h3, rdBack);
        host_u.measure(per, hi);
        host_u.measure(per, hi);
        chk("errPer", 2 * basePer, per);
        chk("errHigh", 2 * basePer * 175 / 800, hi);
        apb(1'b1, `AOP_CTRL_OFS, 32'h1, rdBack);
        repeat (5 * basePer) @(posedge clk);
        chk("tristate", 32'h0, {31'h0, pwmOe});
        $display("pwm test done");
    endtask
    // Slow registers follow their inputs only at their own intervals
    task automatic test_slow();
        rdChk("zcd", `AOP_ZCD_OFS, 32'h0ABC);
        rdChk("gauss", `AOP_GAUSS_OFS, 32'h1357);
        zcdIn   <= 15'h0123;
        gaussIn <= 16'h4567;
        repeat (`AOP_ZCD_CYC) @(posedge clk);
        rdChk("zcdNew", `AOP_ZCD_OFS, 32'h0123);
        repeat (`AOP_GAUSS_CYC - `AOP_ZCD_CYC) @(posedge clk);
        rdChk("gaussNew", `AOP_GAUSS_OFS, 32'h4567);
        $display("slow register test done");
    endtask
    // Clock enable low freezes the angle path, which resumes afterwards
    task automatic test_freeze();
        clkEn    <= 1'b0;
        rawAngle <= 15'h0020;
        repeat (300) @(posedge clk);
        chk("frozen", 32'h7FFF, {17'h0, incAngle});
        clkEn <= 1'b1;
        repeat (300) @(posedge clk);
        chk("thawed", 32'h0010, {17'h0, incAngle});
        $display("freeze test done");
    endtask
    // Watchdog
    initial begin
        repeat (60000) @(posedge clk);
        err_count++;
        $display("[ERR] run time exp done got hang");
        results();
    end
    // Main sequence
    initial begin
        {rst, psel, penable, pwrite, paddr, pwdata} = {1'b1, 47'h0};
        {faultIn, rawAngle, zcdIn, gaussIn} = {12'h0, 15'h10, 15'h0ABC, 16'h1357};
        {nvmCtrl, nvmZeroOffset, err_count, checked} = {32'h4, 15'h10, 64'h0};
        clkEn = 1'b1;
        test_reset();
        test_angle();
        test_pwm();
        test_slow();
        test_freeze();
        results();
    end
endmodule // tb_top
